// *** rtl/sse_pkg.sv ***
// Package with register map, field layout and timing constants of the serial encoder.
package sse_pkg;
  localparam int unsigned                 DATA_W          = 20;
  localparam int unsigned                 CLK_HZ          = 50_000_000;
  localparam logic [11:0]                 FMT_REG_IDX     = 12'h00b;
  localparam logic [11:0]                 FMT_REG_ADDR    = 12'h02c;
  localparam logic [11:0]                 CTRL_REG_ADDR   = 12'h100;
  localparam logic [11:0]                 STAT_REG_ADDR   = 12'h104;
  localparam logic [11:0]                 TPG_REG_ADDR    = 12'h108;
  localparam int unsigned                 FMT_HD_RESTRICTED_MODE_BIT = 5;
  localparam int unsigned                 FMT_SET_LSB     = 0;
  localparam int unsigned                 FMT_SET_W       = 5;
  localparam logic [9:0]                  FMT_RESET       = 10'h000;
  localparam logic [9:0]                  FMT_GENERAL_HD  = 10'h3ff;
  localparam logic [9:0]                  TRS_WORD0       = 10'h3ff;
  localparam logic [9:0]                  TRS_WORD1       = 10'h000;
  localparam int unsigned                 CTRL_EN_BIT     = 0;
  localparam int unsigned                 CTRL_TRSDIS_BIT = 1;
  localparam int unsigned                 CTRL_EDH_BIT    = 2;
  localparam int unsigned                 CTRL_TPG_BIT    = 3;
  localparam int unsigned                 CTRL_W8_BIT     = 4;
  localparam int unsigned                 CTRL_HD_BIT     = 5;
  localparam int unsigned                 CTRL_SCR_BIT    = 6;
  localparam int unsigned                 CTRL_NRZI_BIT   = 7;
  localparam logic [7:0]                  CTRL_RESET      = 8'hc1;
  localparam logic [4:0]                  TPG_RESET       = 5'h00;
  localparam int unsigned                 LOCK_TIME_US    = 20;
  localparam int unsigned                 LOCK_CYCLES     = LOCK_TIME_US * (CLK_HZ / 1_000_000);
  localparam logic [31:0]                 BUS_ERR_DATA    = 32'h0000_0000;
  typedef enum logic [1:0] {SSE_PAT_BLACK, SSE_PAT_PLL, SSE_PAT_EQ, SSE_PAT_BARS} sse_pattern_t;
endpackage : sse_pkg

// *** rtl/sse_bit_if.sv ***
// Interface carrying parallel words, scrambled in the low 10 bits only, from the encoder front end to the serializer.
`timescale 1ns/1ps
interface sse_bit_if;
  logic [sse_pkg::DATA_W-1:0] word;
  logic                       valid;
  logic                       ready;
  logic                       wide;
  logic                       narrow8;
  logic                       nrzi_en;
  logic                       enable;
  modport src (output word, output valid, input ready, output wide, output narrow8, output nrzi_en, output enable);
  modport dst (input word, input valid, output ready, input wide, input narrow8, input nrzi_en, input enable);
endinterface : sse_bit_if

// *** rtl/sse_serializer.sv ***
// Serializer that shifts words out LSB first and applies NRZI coding.
`timescale 1ns/1ps
module sse_serializer (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic bit_en,
  sse_bit_if.dst    link,
  output logic      line_out
);
  typedef struct packed {
    logic [sse_pkg::DATA_W-1:0] sh;
    logic [4:0]                 left;
    logic                       level;
  } sse_ser_state_t;

  sse_ser_state_t s_q;
  sse_ser_state_t s_d;
  logic [4:0]     len;

  always_comb begin
    len = link.wide ? 5'd20 : (link.narrow8 ? 5'd8 : 5'd10);
  end

  assign link.ready = link.enable && (s_q.left == 5'd0);

  always_comb begin
    s_d = s_q;
    if (link.ready && link.valid) begin
      s_d.sh   = link.word;
      s_d.left = len;
    end else if (bit_en && s_q.left != 5'd0) begin
      if (link.nrzi_en) begin
        s_d.level = s_q.level ^ s_q.sh[0];
      end else begin
        s_d.level = s_q.sh[0];
      end
      s_d.sh   = s_q.sh >> 1;
      s_d.left = s_q.left - 5'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign line_out = s_q.level;
endmodule : sse_serializer

// *** rtl/sse_encoder.sv ***
// Top of the serial video encoder: APB registers, input capture, pattern generator, scrambler.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Capture each parallel word into input register.
// - Scramble with x^9 + x^4 + 1.
// - Convert serial NRZ stream to NRZI.
// - Bit clock derived from the word clock.
// - Accept generic 8 or 10 bit words.
// - Input disables timing reference detection.
// - Output shows serial clock lock.
// - Four test patterns, also for self-test.
// - Pattern register bit 2 inverts the bars pattern; bits 4:3 unused.
// - Error check word accumulated into status register; sub-functions separately enabled.
// - SD words 10 bits, HD words 20.
// - Line rate one bit per pclk cycle once locked, 50 Mbps at CLK_HZ.
// - Format bit 5 forces Hd_restricted_mode.
// - Bits 4:0 are stored but select no sub-format; only 0x3ff (general HD) is decoded.
// - General HD defeats format and reference detection.
// - General HD disables EAV/SAV indicators.
// - No line numbers, CRC, ancillary without indicators.
// - Reference is 0x3ff, 0x000, 0x000.
module sse_encoder #(
  parameter int unsigned LOCK_CNT = sse_pkg::LOCK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [19:0] video_in,
  input  wire logic        video_valid,
  output logic             video_ready,
  input  wire logic        trs_detect_disable,
  input  wire logic        rate_change,
  output logic             pll_locked,
  output logic             trs_seen,
  output logic             serial_out
);
  typedef struct packed {
    logic [9:0]  fmt;
    logic [7:0]  ctrl;
    logic [4:0]  test_pattern_generator;
    logic [19:0] in_word;
    logic        in_valid;
    logic [8:0]  scr;
    logic [1:0]  trs_cnt;
    logic        trs_seen;
    logic [15:0] lock_cnt;
    logic        locked;
    logic [10:0] tpg_pos;
    logic [9:0]  edh_crc;
    logic [31:0] rdata;
    logic [1:0]  dis_sync;
    logic [1:0]  rc_sync;
    logic        rc_last;
  } sse_enc_state_t;

  sse_enc_state_t s_q;
  sse_enc_state_t s_d;
  sse_bit_if      link ();
  logic           wr_fire;
  logic           rd_fire;
  logic           hd_forced;
  logic           trs_on;
  logic [9:0]     src_word;
  logic [9:0]     pat_word;
  logic [9:0]     scr_word;
  logic [8:0]     scr_next;
  logic [19:0]    out_word;
  logic           addr_ok;
  logic           take;
  logic           bit_en;

  assign pready  = 1'b1;
  assign wr_fire = psel && penable && pwrite;
  assign rd_fire = psel && penable && !pwrite;
  assign addr_ok = (paddr == sse_pkg::FMT_REG_ADDR) || (paddr == sse_pkg::CTRL_REG_ADDR) ||
                   (paddr == sse_pkg::STAT_REG_ADDR) || (paddr == sse_pkg::TPG_REG_ADDR);
  assign pslverr = psel && penable && !addr_ok;

  assign hd_forced = (s_q.fmt == sse_pkg::FMT_GENERAL_HD);
  assign trs_on    = !s_q.dis_sync[1] && !s_q.ctrl[sse_pkg::CTRL_TRSDIS_BIT] && !hd_forced;

  always_comb begin
    case (sse_sse_pat(s_q.test_pattern_generator[1:0]))
      sse_pkg::SSE_PAT_BLACK: pat_word = s_q.tpg_pos[0] ? 10'h040 : 10'h200;
      sse_pkg::SSE_PAT_PLL:   pat_word = s_q.tpg_pos[0] ? 10'h110 : 10'h300;
      sse_pkg::SSE_PAT_EQ:    pat_word = s_q.tpg_pos[0] ? 10'h198 : 10'h300;
      sse_pkg::SSE_PAT_BARS:  pat_word = {s_q.tpg_pos[10:8] ^ {3{s_q.test_pattern_generator[2]}}, 7'h40};
      default:                pat_word = 10'h040;
    endcase
  end

  function automatic sse_pkg::sse_pattern_t sse_sse_pat(input logic [1:0] v);
    sse_sse_pat = sse_pkg::sse_pattern_t'(v);
  endfunction : sse_sse_pat

  assign src_word = s_q.ctrl[sse_pkg::CTRL_TPG_BIT] ? pat_word : s_q.in_word[9:0];

  always_comb begin
    scr_next = s_q.scr;
    for (int i = 0; i < 10; i++) begin
      scr_word[i] = src_word[i] ^ scr_next[8] ^ scr_next[3];
      scr_next    = {scr_next[7:0], scr_word[i]};
    end
    if (!s_q.ctrl[sse_pkg::CTRL_SCR_BIT]) begin
      scr_word = src_word;
      scr_next = s_q.scr;
    end
  end

  assign out_word = link.wide ? {s_q.in_word[19:10], scr_word} : {10'h000, scr_word};

  assign link.word    = out_word;
  assign link.valid   = s_q.in_valid || s_q.ctrl[sse_pkg::CTRL_TPG_BIT];
  assign link.wide    = s_q.ctrl[sse_pkg::CTRL_HD_BIT] || s_q.fmt[sse_pkg::FMT_HD_RESTRICTED_MODE_BIT];
  assign link.narrow8 = s_q.ctrl[sse_pkg::CTRL_W8_BIT];
  assign link.nrzi_en = s_q.ctrl[sse_pkg::CTRL_NRZI_BIT];
  assign link.enable  = s_q.ctrl[sse_pkg::CTRL_EN_BIT] && s_q.locked;
  assign take         = link.valid && link.ready;
  assign bit_en       = s_q.locked;
  assign video_ready  = !s_q.in_valid || take;

  always_comb begin
    s_d          = s_q;
    s_d.dis_sync = {s_q.dis_sync[0], trs_detect_disable};
    s_d.rc_sync  = {s_q.rc_sync[0], rate_change};
    s_d.rc_last  = s_q.rc_sync[1];
    if (take) begin
      s_d.in_valid = 1'b0;
      s_d.scr      = scr_next;
      s_d.tpg_pos  = s_q.tpg_pos + 11'd1;
      s_d.edh_crc  = s_q.ctrl[sse_pkg::CTRL_EDH_BIT] && !hd_forced ? s_q.edh_crc ^ scr_word : s_q.edh_crc;
    end
    if (video_valid && video_ready) begin
      s_d.in_word  = video_in;
      s_d.in_valid = 1'b1;
      if (trs_on) begin
        if (video_in[9:0] == sse_pkg::TRS_WORD0) begin
          s_d.trs_cnt = 2'd1;
        end else if (video_in[9:0] == sse_pkg::TRS_WORD1 && s_q.trs_cnt != 2'd0) begin
          s_d.trs_cnt = (s_q.trs_cnt == 2'd2) ? 2'd0 : 2'd2;
          s_d.trs_seen = (s_q.trs_cnt == 2'd2);
        end else begin
          s_d.trs_cnt = 2'd0;
        end
      end else begin
        s_d.trs_cnt  = 2'd0;
        s_d.trs_seen = 1'b0;
      end
    end
    if (s_q.rc_sync[1] != s_q.rc_last) begin
      s_d.lock_cnt = '0;
      s_d.locked   = 1'b0;
    end else if (s_q.lock_cnt == 16'(LOCK_CNT)) begin
      s_d.locked = 1'b1;
    end else begin
      s_d.lock_cnt = s_q.lock_cnt + 16'd1;
    end
    if (wr_fire) begin
      case (paddr)
        sse_pkg::FMT_REG_ADDR:  s_d.fmt  = pwdata[9:0];
        sse_pkg::CTRL_REG_ADDR: s_d.ctrl = pwdata[7:0];
        sse_pkg::TPG_REG_ADDR:  s_d.test_pattern_generator  = pwdata[4:0];
        default:                s_d.fmt  = s_q.fmt;
      endcase
    end
    case (paddr)
      sse_pkg::FMT_REG_ADDR:  s_d.rdata = {22'h000000, s_q.fmt};
      sse_pkg::CTRL_REG_ADDR: s_d.rdata = {24'h000000, s_q.ctrl};
      sse_pkg::TPG_REG_ADDR:  s_d.rdata = {27'h0000000, s_q.test_pattern_generator};
      sse_pkg::STAT_REG_ADDR: s_d.rdata = {20'h00000, s_q.edh_crc, s_q.trs_seen, s_q.locked};
      default:                s_d.rdata = sse_pkg::BUS_ERR_DATA;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.fmt  <= sse_pkg::FMT_RESET;
      s_q.ctrl <= sse_pkg::CTRL_RESET;
      s_q.test_pattern_generator  <= sse_pkg::TPG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    prdata = rd_fire ? s_d.rdata : 32'h0000_0000;
  end

  assign pll_locked = s_q.locked;
  assign trs_seen   = s_q.trs_seen;

  sse_serializer u_ser (
    .pclk     (pclk),
    .presetn  (presetn),
    .bit_en   (bit_en),
    .link     (link),
    .line_out (serial_out)
  );
endmodule : sse_encoder

// *** dv/sse_encoder_sva.sv ***
// Checker of the encoder port behaviour, bound to the top module.
`timescale 1ns/1ps
module sse_encoder_chk #(
  parameter int unsigned LOCK_CNT = 20
) (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [19:0] video_in,
  input logic        video_valid,
  input logic        video_ready,
  input logic        trs_detect_disable,
  input logic        rate_change,
  input logic        pll_locked,
  input logic        trs_seen,
  input logic        serial_out
);
  logic [15:0] low_q;
  logic [9:0]  w1_q, w0_q;
  logic        trs_q;
  wire         acc = video_valid && video_ready;
  wire         hit = paddr == sse_pkg::FMT_REG_ADDR || paddr == sse_pkg::CTRL_REG_ADDR ||
                     paddr == sse_pkg::STAT_REG_ADDR || paddr == sse_pkg::TPG_REG_ADDR;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= '0;
      w1_q  <= '0;
      w0_q  <= '0;
      trs_q <= 1'b0;
    end else begin
      low_q <= pll_locked ? 16'h0000 : low_q + 16'h0001;
      if (acc) begin
        w1_q  <= w0_q;
        w0_q  <= video_in[9:0];
        trs_q <= trs_q | (w1_q == sse_pkg::TRS_WORD0 && w0_q == sse_pkg::TRS_WORD1 &&
                          video_in[9:0] == sse_pkg::TRS_WORD1);
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_ready: assert property (psel && penable |-> pready) else $error("pready low in access");
  a_unmapped_err: assert property (psel && penable && !hit |-> pslverr && prdata == sse_pkg::BUS_ERR_DATA)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && hit |-> !pslverr) else $error("mapped access refused");
  a_lock_wait: assert property ($rose(pll_locked) |-> low_q >= LOCK_CNT) else $error("lock came early");
  a_lock_drop: assert property ($changed(rate_change) |-> ##[1:4] !pll_locked) else $error("lock kept");
  a_idle_line: assert property (!pll_locked && !$past(pll_locked) |=> $stable(serial_out))
    else $error("line moved while unlocked");
  a_trs_cause: assert property ($rose(trs_seen) |-> trs_q) else $error("reference flag without sequence");
  a_trs_block: assert property ($rose(trs_seen) |-> !$past(trs_detect_disable, 3))
    else $error("reference flag while disabled");
  a_reset_out: assert property (disable iff (1'b0) !presetn |=> !serial_out && !pll_locked && !trs_seen && video_ready)
    else $error("outputs not at reset level");
  c_lock: cover property ($rose(pll_locked));
  c_trs: cover property ($rose(trs_seen));
  c_err: cover property (psel && penable && pslverr);
  c_word: cover property (acc);
endmodule : sse_encoder_chk
bind sse_encoder sse_encoder_chk #(.LOCK_CNT(LOCK_CNT)) i_sse_encoder_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .video_in(video_in), .video_valid(video_valid), .video_ready(video_ready), .rate_change(rate_change),
  .trs_detect_disable(trs_detect_disable), .pll_locked(pll_locked), .trs_seen(trs_seen), .serial_out(serial_out));

// *** dv/sse_src.sv ***
// Model of the parallel video source feeding the encoder.
`timescale 1ns/1ps
module sse_src (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        video_ready,
  output logic      [19:0] video_in,
  output logic             video_valid
);
  logic [19:0] q[$];
  task automatic push(input logic [19:0] w);
    q.push_back(w);
  endtask : push
  initial begin
    video_in = 20'h00000;
    video_valid = 1'b0;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      video_valid <= 1'b0;
    end else if (!(video_valid && !video_ready)) begin
      if (video_valid) void'(q.pop_front());
      if (q.size() > 0) begin
        video_in <= q[0];
        video_valid <= 1'b1;
      end else begin
        video_in <= ~video_in;
        video_valid <= 1'b0;
      end
    end
  end
endmodule : sse_src

// *** dv/test_sse_encoder.sv ***
// Testbench of the serial video encoder.
`timescale 1ns/1ps
module test_sse_encoder;
  localparam int unsigned LOCK = 20;
  localparam logic [7:0]  MODE [3] = '{8'h81, 8'h91, 8'ha1};
  localparam logic [19:0] MSK [3] = '{20'h003ff, 20'h000ff, 20'hfffff};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, video_valid, video_ready, pll_locked, trs_seen, serial_out, last_q = 1'b0;
  logic        trs_detect_disable = 1'b0, rate_change = 1'b0;
  logic [19:0] video_in;
  int          n_mismatch = 0, n_compared = 0, ntog = 0, t0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    if (serial_out !== last_q) ntog++;
    last_q = serial_out;
  end
  sse_encoder #(.LOCK_CNT(LOCK)) i_sse_encoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .video_in(video_in), .video_valid(video_valid), .video_ready(video_ready), .rate_change(rate_change),
    .trs_detect_disable(trs_detect_disable), .pll_locked(pll_locked), .trs_seen(trs_seen), .serial_out(serial_out));
  sse_src i_sse_src (.pclk(pclk), .presetn(presetn), .video_ready(video_ready), .video_in(video_in),
    .video_valid(video_valid));
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
    chk("slave error", {31'h0, ex}, {31'h0, e});
  endtask : rd
  task automatic trs();
    i_sse_src.push(20'h003ff);
    i_sse_src.push(20'h00000);
    i_sse_src.push(20'h00000);
    i_sse_src.push(20'h00200);
    repeat (80) @(posedge pclk);
  endtask : trs
  task automatic wait_lock();
    for (int i = 0; i < 200 && pll_locked !== 1'b1; i++) @(posedge pclk);
  endtask : wait_lock
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("ctrl", sse_pkg::CTRL_REG_ADDR, {24'h0, sse_pkg::CTRL_RESET}, 1'b0);
    rd("format", sse_pkg::FMT_REG_ADDR, {22'h0, sse_pkg::FMT_RESET}, 1'b0);
    rd("pattern", sse_pkg::TPG_REG_ADDR, {27'h0, sse_pkg::TPG_RESET}, 1'b0);
    rd("unmapped", 12'h0f0, 32'h0, 1'b1);
    for (logic [31:0] v = 32'h0; v < 32'h10; v++) begin
      wr(sse_pkg::TPG_REG_ADDR, v);
      rd("pattern", sse_pkg::TPG_REG_ADDR, v, 1'b0);
    end
    wait_lock();
    rd("status", sse_pkg::STAT_REG_ADDR, 32'h1, 1'b0);
    rate_change <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("lock lost", 32'h0, {31'h0, pll_locked});
    wait_lock();
    chk("lock back", 32'h1, {31'h0, pll_locked});
    rate_change <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("lock lost again", 32'h0, {31'h0, pll_locked});
    wait_lock();
    chk("lock back again", 32'h1, {31'h0, pll_locked});
    trs_detect_disable <= 1'b1;
    repeat (4) @(posedge pclk);
    trs();
    chk("reference disabled", 32'h0, {31'h0, trs_seen});
    trs_detect_disable <= 1'b0;
    wr(sse_pkg::FMT_REG_ADDR, {22'h0, sse_pkg::FMT_GENERAL_HD});
    rd("format", sse_pkg::FMT_REG_ADDR, 32'h3ff, 1'b0);
    trs();
    chk("reference forced hd", 32'h0, {31'h0, trs_seen});
    wr(sse_pkg::FMT_REG_ADDR, 32'h0);
    trs();
    chk("reference seen", 32'h1, {31'h0, trs_seen});
    for (int i = 0; i < 3; i++) begin
      wr(sse_pkg::CTRL_REG_ADDR, {24'h0, MODE[i]});
      repeat (20) @(posedge pclk);
      t0 = ntog;
      i_sse_src.push(20'hf35a7);
      repeat (60) @(posedge pclk);
      chk("line toggles", 32'($countones(20'hf35a7 & MSK[i])), 32'(ntog - t0));
    end
    wr(sse_pkg::CTRL_REG_ADDR, 32'h80);
    t0 = ntog;
    i_sse_src.push(20'hf35a7);
    repeat (60) @(posedge pclk);
    chk("disabled toggles", 32'h0, 32'(ntog - t0));
    end_sim();
  end
endmodule : test_sse_encoder
